// *** verilog/dpc_consts.svh ***
// offsets, field positions, reset values for the downstream port config registers
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH
`define DPC_OFF_CHARGE 8'h06
`define DPC_OFF_REMOVABLE 8'h07
`define DPC_OFF_IN_SERVICE 8'h08
`define DPC_OFF_LEGACY 8'h09
`define DPC_OFF_DEVCFG2 8'h0a
`define DPC_UNLOCK_BIT 7
`define DPC_PORT_MSB 3
`define DPC_RST_IN_SERVICE 4'hf
`define DPC_RST_DEVCFG2 8'h10
`define DPC_DEVCFG2_RO_MASK 8'h81
`endif

// *** verilog/dpc_pkg.sv ***
// types shared by the downstream port config register bank
package dpc_pkg;
   typedef logic [3:0] dpc_port_mask_t;
   typedef enum {DPC_SEL_NONE, DPC_SEL_CHARGE, DPC_SEL_REMOVABLE, DPC_SEL_IN_SERVICE,
      DPC_SEL_LEGACY, DPC_SEL_DEVCFG2} dpc_sel_t;
endpackage : dpc_pkg

// *** verilog/dpc_port_map.sv ***
// per-port enable resolution from in-service and legacy-speed-only masks
`timescale 1ns/1ns
module dpc_port_map
   import dpc_pkg::*;
(
   input wire dpc_port_mask_t in_service, // port used mask, bit n is port n+1
   input wire dpc_port_mask_t legacy_speed_only, // port restricted to usb 2.0 side
   output dpc_port_mask_t usb2_enable, // usb 2.0 side enabled per port
   output dpc_port_mask_t usb3_enable // superspeed side enabled per port
);
   // legacy-only ports keep the usb 2.0 side up whatever the used bit says
   assign usb2_enable = in_service | legacy_speed_only;
   assign usb3_enable = in_service & ~legacy_speed_only;
endmodule : dpc_port_map

// *** verilog/dpc_regs.sv ***
// downstream port configuration register bank with otp/unlock selection
// Operation
// - unused bits read zero, writes ignored
// - charge bit one means port charges
// - charge bit n drives port n+1
// - charge field takes strap pins at release
// - serial config mode may overwrite charge field
// - removable bit 7 unlocks three fields
// - locked fields read-only, values from otp
// - unlocked fields take writes, read back
// - unlock write also loads removable field
// - removable bit per port n+1
// - locked removable is inverted otp setting
// - used bit enables port n+1
// - legacy-only port keeps usb 2.0 enabled
`timescale 1ns/1ns
`include "dpc_consts.svh"
module dpc_regs
   import dpc_pkg::*;
(
   input wire logic ref_clk, // 100 mhz clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic clk_en, // freezes all state while low
   input wire logic serial_cfg_mode, // i2c/smbus configuration mode selected
   input wire logic [3:0] power_charge_strap_pins, // strap levels sampled at release
   input wire logic [3:0] otp_non_removable, // otp non-removable setting
   input wire logic [3:0] otp_in_service, // otp port used setting
   input wire logic [3:0] otp_legacy_speed_only, // otp usb 2.0 only setting
   input wire logic reg_wr, // byte write strobe from eeprom loader or smbus
   input wire logic reg_rd, // byte read strobe
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata_q, // read data, valid the cycle after reg_rd
   output logic reg_rvalid_q, // read data valid pulse
   output logic [3:0] port_charge_enable_q, // charging features per port
   output logic [3:0] port_removable_q, // removable flag per port
   output logic [3:0] port_usb2_enable_q, // usb 2.0 side enabled per port
   output logic [3:0] port_usb3_enable_q, // superspeed side enabled per port
   output logic removable_write_unlock_q // unlock state
);
   // ****************************************
   // decode
   // ****************************************
   // offsets outside the map decode to none: writes drop, reads give zero
   function automatic dpc_sel_t dpc_decode(input logic [7:0] addr);
      case (addr)
         `DPC_OFF_CHARGE: dpc_decode = DPC_SEL_CHARGE;
         `DPC_OFF_REMOVABLE: dpc_decode = DPC_SEL_REMOVABLE;
         `DPC_OFF_IN_SERVICE: dpc_decode = DPC_SEL_IN_SERVICE;
         `DPC_OFF_LEGACY: dpc_decode = DPC_SEL_LEGACY;
         `DPC_OFF_DEVCFG2: dpc_decode = DPC_SEL_DEVCFG2;
         default: dpc_decode = DPC_SEL_NONE;
      endcase
   endfunction : dpc_decode

   // writes decode only under the strobe, reads from the address alone
   dpc_sel_t wr_sel;
   dpc_sel_t rd_sel;
   assign wr_sel = reg_wr ? dpc_decode(reg_addr) : DPC_SEL_NONE;
   assign rd_sel = dpc_decode(reg_addr);

   // ****************************************
   // stored state
   // ****************************************
   // strap flag clears only in reset, so straps are taken once per release
   logic strap_taken_q, strap_taken_d;
   dpc_port_mask_t charge_q, charge_d;
   logic unlock_q, unlock_d;
   dpc_port_mask_t rmbl_q, rmbl_d;
   dpc_port_mask_t used_q, used_d;
   dpc_port_mask_t legacy_q, legacy_d;
   logic [7:0] devcfg2_q, devcfg2_d;

   // next values of the stored fields
   always_comb
   begin
      strap_taken_d = 1'b1;
      charge_d = charge_q;
      unlock_d = unlock_q;
      rmbl_d = rmbl_q;
      used_d = used_q;
      legacy_d = legacy_q;
      devcfg2_d = devcfg2_q;
      // first enabled edge after release: straps win over any write
      if (!strap_taken_q)
      begin
         charge_d = power_charge_strap_pins;
      end
      else if (wr_sel == DPC_SEL_CHARGE && serial_cfg_mode)
      begin
         charge_d = reg_wdata[`DPC_PORT_MSB:0];
      end
      if (wr_sel == DPC_SEL_REMOVABLE)
      begin
         unlock_d = reg_wdata[`DPC_UNLOCK_BIT];
      end
      if (!unlock_q)
      begin
         // locked copies track otp so unlocking starts from those values
         rmbl_d = ~otp_non_removable;
         used_d = otp_in_service;
         legacy_d = otp_legacy_speed_only;
      end
      // unlock bit and removable field load in the same write
      if (wr_sel == DPC_SEL_REMOVABLE && (unlock_q || reg_wdata[`DPC_UNLOCK_BIT]))
      begin
         rmbl_d = reg_wdata[`DPC_PORT_MSB:0];
      end
      // used and legacy fields take writes only while unlocked
      if (unlock_q && wr_sel == DPC_SEL_IN_SERVICE)
      begin
         used_d = reg_wdata[`DPC_PORT_MSB:0];
      end
      if (unlock_q && wr_sel == DPC_SEL_LEGACY)
      begin
         legacy_d = reg_wdata[`DPC_PORT_MSB:0];
      end
      // second config register keeps its read-only bits at reset level
      if (wr_sel == DPC_SEL_DEVCFG2)
      begin
         devcfg2_d = (reg_wdata & ~`DPC_DEVCFG2_RO_MASK) | (devcfg2_q & `DPC_DEVCFG2_RO_MASK);
      end
   end

   // register the stored fields
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // fields come out of reset locked, straps not yet taken
         strap_taken_q <= 1'b0;
         charge_q <= 4'h0;
         unlock_q <= 1'b0;
         rmbl_q <= 4'h0;
         used_q <= `DPC_RST_IN_SERVICE;
         legacy_q <= 4'h0;
         devcfg2_q <= `DPC_RST_DEVCFG2;
      end
      else if (clk_en)
      begin
         strap_taken_q <= strap_taken_d;
         charge_q <= charge_d;
         unlock_q <= unlock_d;
         rmbl_q <= rmbl_d;
         used_q <= used_d;
         legacy_q <= legacy_d;
         devcfg2_q <= devcfg2_d;
      end
   end

   // ****************************************
   // effective values and read data
   // ****************************************
   // effective values pick otp or the stored copy by unlock state
   dpc_port_mask_t rmbl_eff;
   dpc_port_mask_t used_eff;
   dpc_port_mask_t legacy_eff;
   dpc_port_mask_t usb2_en;
   dpc_port_mask_t usb3_en;
   logic [7:0] rdata_d;

   // locked fields show otp directly, unlocked fields show what was stored
   // otp pins are read live, so a change while locked shows at once
   assign rmbl_eff = unlock_q ? rmbl_q : ~otp_non_removable;
   assign used_eff = unlock_q ? used_q : otp_in_service;
   assign legacy_eff = unlock_q ? legacy_q : otp_legacy_speed_only;

   // ****************************************
   // port side enables
   // ****************************************
   // usb 2.0 and superspeed enables from the effective masks
   dpc_port_map u_port_map
   (
      .in_service(used_eff),
      .legacy_speed_only(legacy_eff),
      .usb2_enable(usb2_en),
      .usb3_enable(usb3_en)
   );

   // read mux, unused bits return zero; data holds until the next read
   always_comb
   begin
      rdata_d = reg_rdata_q;
      if (reg_rd)
      begin
         case (rd_sel)
            DPC_SEL_CHARGE: rdata_d = {4'h0, charge_q};
            DPC_SEL_REMOVABLE: rdata_d = {unlock_q, 3'h0, rmbl_eff};
            DPC_SEL_IN_SERVICE: rdata_d = {4'h0, used_eff};
            DPC_SEL_LEGACY: rdata_d = {4'h0, legacy_eff};
            DPC_SEL_DEVCFG2: rdata_d = devcfg2_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // register all outputs
   // outputs lag the fields by one edge so every pin leaves a flop
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata_q <= 8'h00;
         reg_rvalid_q <= 1'b0;
         port_charge_enable_q <= 4'h0;
         port_removable_q <= 4'h0;
         port_usb2_enable_q <= 4'h0;
         port_usb3_enable_q <= 4'h0;
         removable_write_unlock_q <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_rdata_q <= rdata_d;
         reg_rvalid_q <= reg_rd;
         port_charge_enable_q <= charge_q;
         port_removable_q <= rmbl_eff;
         port_usb2_enable_q <= usb2_en;
         port_usb3_enable_q <= usb3_en;
         removable_write_unlock_q <= unlock_q;
      end
   end
endmodule : dpc_regs

// *** verif/dpc_regs_chk.sv ***
// assertion checker for the port config register bank
`timescale 1ns/1ns
`include "dpc_consts.svh"
module dpc_regs_chk (
   input wire logic ref_clk, // clock
   input wire logic reset_n, // reset
   input wire logic clk_en, // run
   input wire logic [3:0] power_charge_strap_pins, // straps
   input wire logic reg_wr, // write
   input wire logic reg_rd, // read
   input wire logic [7:0] reg_addr, // offset
   input wire logic [7:0] reg_wdata, // data in
   input wire logic [7:0] reg_rdata_q, // data out
   input wire logic reg_rvalid_q, // read valid
   input wire logic [3:0] port_charge_enable_q, // charge
   input wire logic [3:0] port_removable_q, // removable
   input wire logic [3:0] port_usb2_enable_q, // usb2 side
   input wire logic [3:0] port_usb3_enable_q, // usb3 side
   input wire logic removable_write_unlock_q // unlock
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // read answer timing, reserved bits, and no usb3 side without the usb2 side
   rd_valid_a: assert property (clk_en && reg_rd |=> reg_rvalid_q) else $error("no read valid");
   no_valid_a: assert property (clk_en && !reg_rd |=> !reg_rvalid_q) else $error("stray read valid");
   charge_rsvd_a: assert property (clk_en && reg_rd && reg_addr == `DPC_OFF_CHARGE |=>
      reg_rdata_q[7:4] == 4'h0) else $error("charge upper bits set");
   rmbl_rsvd_a: assert property (clk_en && reg_rd && reg_addr == `DPC_OFF_REMOVABLE |=>
      reg_rdata_q[6:4] == 3'h0) else $error("removable middle bits set");
   unlock_rd_a: assert property (clk_en && reg_rd && reg_addr == `DPC_OFF_REMOVABLE |=>
      reg_rdata_q[7] == removable_write_unlock_q) else $error("unlock read mismatch");
   unmapped_read_a: assert property (clk_en && reg_rd && reg_addr > 8'h0a |=> reg_rdata_q == 8'h00)
      else $error("unmapped read not zero");
   legacy_sub_a: assert property ((port_usb3_enable_q & ~port_usb2_enable_q) == 4'h0)
      else $error("usb3 without usb2");
   // strap capture and unlocking write
   strap_capture_a: assert property ($rose(reset_n) |-> ##2 port_charge_enable_q == $past(power_charge_strap_pins, 2))
      else $error("straps not captured");
   // low clock enable freezes the charge, removable, unlock and read outputs
   freeze_hold_a: assert property (!clk_en |=> $stable(port_charge_enable_q) && $stable(port_removable_q) &&
      $stable(removable_write_unlock_q) && $stable(reg_rdata_q) && $stable(reg_rvalid_q))
      else $error("outputs moved while frozen");
   unlock_wr_a: assert property (clk_en && reg_wr && reg_addr == `DPC_OFF_REMOVABLE && reg_wdata[7] |->
      ##2 removable_write_unlock_q && {4'h0, port_removable_q} == ($past(reg_wdata, 2) & 8'h0f))
      else $error("unlock write not applied");
endmodule : dpc_regs_chk
bind dpc_regs dpc_regs_chk dpc_regs_chk_inst
(
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .clk_en(clk_en),
   .power_charge_strap_pins(power_charge_strap_pins),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata_q(reg_rdata_q),
   .reg_rvalid_q(reg_rvalid_q),
   .port_charge_enable_q(port_charge_enable_q),
   .port_removable_q(port_removable_q),
   .port_usb2_enable_q(port_usb2_enable_q),
   .port_usb3_enable_q(port_usb3_enable_q),
   .removable_write_unlock_q(removable_write_unlock_q)
);

// *** verif/dpc_host_model.sv ***
// smbus host model issuing byte writes and reads
`timescale 1ns/1ns
`include "dpc_consts.svh"
module dpc_host_model (
   input wire logic ref_clk, // clock
   input wire logic reg_rvalid_q, // read valid
   input wire logic [7:0] reg_rdata_q, // read data
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [7:0] reg_addr, // offset
   output logic [7:0] reg_wdata // write data
);
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
   // one byte write; released lines show the inverse value
   task wr(input logic [7:0] a, input logic [7:0] d);
      if (a == `DPC_OFF_IN_SERVICE && d[0] == 1'b0) d[2] = 1'b1;
      @(posedge ref_clk) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk) #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // one byte read; a missing valid yields unknown data
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk) #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hxx;
   endtask : rd
endmodule : dpc_host_model

// *** verif/test_dpc_regs.sv ***
// self-checking bench for the port config register bank
`timescale 1ns/1ns
`include "dpc_consts.svh"
module test_dpc_regs;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic serial_cfg_mode = 1'b0;
   logic [3:0] power_charge_strap_pins = 4'ha;
   logic [3:0] otp_non_removable = 4'h6;
   logic [3:0] otp_in_service = 4'hd;
   logic [3:0] otp_legacy_speed_only = 4'h2;
   logic reg_wr, reg_rd, reg_rvalid_q, removable_write_unlock_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rd_val;
   logic [3:0] port_charge_enable_q, port_removable_q, port_usb2_enable_q, port_usb3_enable_q;
   int num_errors = 0;
   int compares = 0;
   always #5 ref_clk = ~ref_clk;
   dpc_regs dpc_regs_inst
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .serial_cfg_mode(serial_cfg_mode),
      .power_charge_strap_pins(power_charge_strap_pins),
      .otp_non_removable(otp_non_removable),
      .otp_in_service(otp_in_service),
      .otp_legacy_speed_only(otp_legacy_speed_only),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q),
      .port_charge_enable_q(port_charge_enable_q),
      .port_removable_q(port_removable_q),
      .port_usb2_enable_q(port_usb2_enable_q),
      .port_usb3_enable_q(port_usb3_enable_q),
      .removable_write_unlock_q(removable_write_unlock_q)
   );
   dpc_host_model dpc_host_model_inst
   (
      .ref_clk(ref_clk),
      .reg_rvalid_q(reg_rvalid_q),
      .reg_rdata_q(reg_rdata_q),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata)
   );
   // compare one byte, count and report
   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task rchk(input logic [7:0] a, input logic [7:0] e);
      dpc_host_model_inst.rd(a, rd_val);
      chk(rd_val, e);
   endtask : rchk
   task report_and_stop;
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // straps land in the charge field
   task t_strap;
      chk({4'h0, port_charge_enable_q}, 8'h0a);
      rchk(`DPC_OFF_CHARGE, 8'h0a);
   endtask : t_strap
   // charge writes refused outside serial mode
   task t_charge;
      dpc_host_model_inst.wr(`DPC_OFF_CHARGE, 8'hff);
      rchk(`DPC_OFF_CHARGE, 8'h0a);
      serial_cfg_mode = 1'b1;
      dpc_host_model_inst.wr(`DPC_OFF_CHARGE, 8'hf3);
      rchk(`DPC_OFF_CHARGE, 8'h03);
      chk({4'h0, port_charge_enable_q}, 8'h03);
   endtask : t_charge
   // low clock enable drops a write and holds the charge output
   task t_freeze;
      clk_en = 1'b0;
      dpc_host_model_inst.wr(`DPC_OFF_CHARGE, 8'h0c);
      chk({4'h0, port_charge_enable_q}, 8'h03);
      clk_en = 1'b1;
      rchk(`DPC_OFF_CHARGE, 8'h03);
   endtask : t_freeze
   // locked fields follow otp and drop writes
   task t_locked;
      rchk(`DPC_OFF_REMOVABLE, 8'h09);
      rchk(`DPC_OFF_LEGACY, 8'h02);
      dpc_host_model_inst.wr(`DPC_OFF_IN_SERVICE, 8'h05);
      dpc_host_model_inst.wr(`DPC_OFF_REMOVABLE, 8'h05);
      rchk(`DPC_OFF_IN_SERVICE, 8'h0d);
      rchk(`DPC_OFF_REMOVABLE, 8'h09);
      chk({port_usb2_enable_q, port_usb3_enable_q}, 8'hfd);
   endtask : t_locked
   // unlock in one write, store, relock
   task t_unlock;
      dpc_host_model_inst.wr(`DPC_OFF_REMOVABLE, 8'h85);
      @(posedge ref_clk) #1;
      chk({removable_write_unlock_q, 3'h0, port_removable_q}, 8'h85);
      rchk(`DPC_OFF_REMOVABLE, 8'h85);
      dpc_host_model_inst.wr(`DPC_OFF_IN_SERVICE, 8'h0e);
      dpc_host_model_inst.wr(`DPC_OFF_LEGACY, 8'h01);
      rchk(`DPC_OFF_IN_SERVICE, 8'h0e);
      rchk(`DPC_OFF_LEGACY, 8'h01);
      chk({port_usb2_enable_q, port_usb3_enable_q}, 8'hfe);
      dpc_host_model_inst.wr(8'h20, 8'hff);
      rchk(8'h20, 8'h00);
      dpc_host_model_inst.wr(`DPC_OFF_REMOVABLE, 8'h03);
      rchk(`DPC_OFF_REMOVABLE, 8'h09);
   endtask : t_unlock
   // second config register: reset pattern, read-only bits stay zero
   task t_devcfg2;
      rchk(`DPC_OFF_DEVCFG2, 8'h10);
      dpc_host_model_inst.wr(`DPC_OFF_DEVCFG2, 8'hff);
      rchk(`DPC_OFF_DEVCFG2, 8'h7e);
   endtask : t_devcfg2
   // main sequence
   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      t_strap;
      t_charge;
      t_freeze;
      t_locked;
      t_unlock;
      t_devcfg2;
      report_and_stop;
   end
   // watchdog against a hang
   initial
   begin
      #20000;
      num_errors++;
      report_and_stop;
   end
endmodule : test_dpc_regs
